// [hw/ppps_consts.svh]
/*
  Constants of the primary port block: cycle counts, field positions
  and reset values. Assumes inclusion by bare name from hw/.
*/
`ifndef PPPS_CONSTS_SVH
`define PPPS_CONSTS_SVH

`define PPPS_CLAIM_WAIT   3'd5
`define PPPS_REQ_GAP      2'd2
`define PPPS_FIFO_W       36
`define PPPS_FIFO_D       32
`define PPPS_BE_LSB       32
`define PPPS_BE_ALL       4'h0
`define PPPS_AD_RESET     32'h0000_0000
`define PPPS_CBE_RESET    4'h0

`endif

// [hw/ppps_pkg.sv]
/*
  Types and the parity function of the primary port block.
  Assumes nothing of its surroundings.
*/
package ppps_pkg;

  typedef enum logic [2:0] {
    PPPS_IDLE = 3'b000,
    PPPS_REQ  = 3'b001,
    PPPS_ADDR = 3'b010,
    PPPS_DATA = 3'b011,
    PPPS_TURN = 3'b100
  } ppps_state_t;

  typedef struct packed {
    ppps_state_t state;
    logic        req_n;
    logic        frame_n;
    logic        frame_oe;
    logic        irdy_n;
    logic        irdy_oe;
    logic [31:0] ad;
    logic        ad_oe;
    logic [3:0]  cbe;
    logic        cbe_oe;
    logic        write;
    logic [3:0]  cmd;
    logic [7:0]  left;
    logic [1:0]  gap;
    logic [2:0]  cnt;
    logic        claimed;
    logic        busy;
    logic        done;
    logic        abort;
    logic        rd_valid;
    logic [31:0] rd_data;
  } ppps_mst_t;

  // parity bit that makes the count of ones over ad, cbe and par even
  function automatic logic ppps_even_par(input logic [31:0] ad,
                                         input logic [3:0]  cbe);
    return ^{ad, cbe};
  endfunction

endpackage

// [hw/ppps_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides; flags are registered.
  Assumes one synchronous clock and an active high synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ppps_fifo #(
  parameter int W = 36,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
    logic                vld;
  } ppps_fifo_st_t;

  ppps_fifo_st_t r_reg, r_next;
  logic push, pop;

  always_comb begin
    r_next = r_reg;
    push = in_valid && r_reg.rdy;
    pop = out_ready && r_reg.vld;
    if (push) begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    r_next.rdy = r_next.cnt != (AW+1)'(D);
    r_next.vld = r_next.cnt != '0;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.rdy <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_ready = r_reg.rdy;
  assign out_valid = r_reg.vld;
  assign out_data = r_reg.mem[r_reg.rp];
endmodule
`default_nettype wire

// [hw/ppps_parity.sv]
/*
  Parity driver and checker of the primary port, one clock behind
  the words it covers. Assumes the driven word and its enable come
  from flip-flops of the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module ppps_parity
  import ppps_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // driven word
  input  wire logic [31:0] ad_drv,
  input  wire logic [3:0]  cbe_drv,
  input  wire logic        ad_drv_oe,
  // received word
  input  wire logic        chk_en,
  input  wire logic [31:0] ad_rx,
  input  wire logic [3:0]  cbe_rx,
  input  wire logic        par_rx,
  // parity pin and error
  output logic             par_o,
  output logic             par_oe,
  output logic             par_err
);
  typedef struct packed {
    logic        par;
    logic        oe;
    logic        chk;
    logic [31:0] ad;
    logic [3:0]  cbe;
    logic        err;
  } ppps_par_st_t;

  ppps_par_st_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    // (R9) parity one clock late
    r_next.par = ppps_even_par(ad_drv, cbe_drv);
    // (R10) enable lags ad enable
    r_next.oe = ad_drv_oe;
    r_next.chk = chk_en;
    r_next.ad = ad_rx;
    r_next.cbe = cbe_rx;
    // (R7) even parity check
    r_next.err = r_reg.chk && (ppps_even_par(r_reg.ad, r_reg.cbe) != par_rx);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign par_o = r_reg.par;
  assign par_oe = r_reg.oe;
  assign par_err = r_reg.err;
endmodule
`default_nettype wire

// [hw/ppps_port.sv]
/*
  Primary bus port: bursts of memory reads and writes as bus master,
  bus parking, request spacing, claim timeout and parity.
  Assumes bus inputs synchronous to clk_sys and pins resolved outside.
*/
// Notes on behaviour
// (R1) released low-active lines driven high once
// (R2) address on bus in frame's first cycle
// (R3) word moves when both readies low
// (R4) driver keeps data stable while ready
// (R5) park ad, cbe, par when granted idle
// (R6) command in address phase, then enables
// (R7) even ones over ad, cbe and parity
// (R8) address parity valid one cycle later
// (R9) data parity valid one clock later
// (R10) parity released one cycle after ad
// (R11) frame high marks final data phase
// (R12) initiator ready held until phase ends
// (R13) target ready held until phase ends
// (R14) no claim in five cycles: abort
// (R15) request high two cycles before reassert
// (R16) reset floats every bus output at once; primary_request_n has no enable and stays driven
`timescale 1ns/10ps
`default_nettype none
`include "ppps_consts.svh"
module ppps_port
  import ppps_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // user request
  input  wire logic        start,
  input  wire logic        start_write,
  input  wire logic [3:0]  start_cmd,
  input  wire logic [31:0] start_addr,
  input  wire logic [7:0]  start_words,
  // user status
  output logic             busy,
  output logic             done,
  output logic             master_abort,
  output logic             parity_error,
  // write words: byte enables low-active above data
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [35:0] wr_word,
  // read words
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  // arbitration
  output logic             primary_request_n,
  input  wire logic        primary_grant_n,
  // address and data
  input  wire logic [31:0] primary_ad_i,
  output logic [31:0]      primary_ad_o,
  output logic             primary_ad_oe,
  input  wire logic [3:0]  primary_cmd_byte_enables_i,
  output logic [3:0]       primary_cmd_byte_enables_o,
  output logic             primary_cmd_byte_enables_oe,
  input  wire logic        primary_parity_bit_i,
  output logic             primary_parity_bit_o,
  output logic             primary_parity_bit_oe,
  // control
  input  wire logic        primary_frame_n_i,
  output logic             primary_frame_n_o,
  output logic             primary_frame_oe,
  input  wire logic        primary_initiator_ready_n_i,
  output logic             primary_initiator_ready_n_o,
  output logic             primary_initiator_ready_oe,
  input  wire logic        primary_target_ready_n_i,
  input  wire logic        primary_target_claim_n_i
);
  ppps_mst_t   r_reg, r_next;
  logic        bus_idle;
  logic        xfer;
  logic        load;
  logic        claim;
  logic [7:0]  left_after;
  logic        f_valid;
  logic [35:0] f_word;
  logic        par_o, par_oe, par_err;
  logic        err_reg;

  assign bus_idle = primary_frame_n_i && primary_initiator_ready_n_i;
  // (R3) both readies low
  // (R13) target ready held by target
  assign xfer = (r_reg.state == PPPS_DATA) && r_reg.irdy_oe
                && !r_reg.irdy_n && !primary_target_ready_n_i;
  assign claim = r_reg.claimed || !primary_target_claim_n_i;
  assign left_after = r_reg.left - 8'(xfer);

  // write words wait here; an empty fifo holds irdy off
  ppps_fifo #(
    .W (`PPPS_FIFO_W),
    .D (`PPPS_FIFO_D)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_word),
    .out_valid (f_valid),
    .out_ready (load),
    .out_data  (f_word)
  );

  // (R8) address parity one cycle late
  ppps_parity u_par (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .ad_drv    (r_reg.ad),
    .cbe_drv   (r_reg.cbe),
    .ad_drv_oe (r_reg.ad_oe),
    .chk_en    (xfer && !r_reg.write),
    .ad_rx     (primary_ad_i),
    .cbe_rx    (primary_cmd_byte_enables_i),
    .par_rx    (primary_parity_bit_i),
    .par_o     (par_o),
    .par_oe    (par_oe),
    .par_err   (par_err)
  );

  always_comb begin
    r_next = r_reg;
    load = 1'b0;
    r_next.done = 1'b0;
    r_next.abort = 1'b0;
    r_next.rd_valid = 1'b0;
    // (R15) count cycles with request high
    if (!r_reg.req_n) begin
      r_next.gap = 2'd0;
    end else if (r_reg.gap != `PPPS_REQ_GAP) begin
      r_next.gap = r_reg.gap + 2'd1;
    end
    case (r_reg.state)
      PPPS_IDLE, PPPS_REQ: begin
        // (R5) park while granted and idle
        r_next.ad_oe = !primary_grant_n && bus_idle;
        r_next.cbe_oe = !primary_grant_n && bus_idle;
        r_next.frame_oe = 1'b0;
        r_next.irdy_oe = 1'b0;
        if (r_reg.state == PPPS_IDLE) begin
          if (start && start_words != 8'h00) begin
            r_next.state = PPPS_REQ;
            r_next.busy = 1'b1;
            r_next.write = start_write;
            r_next.cmd = start_cmd;
            r_next.ad = start_addr;
            r_next.left = start_words;
          end
        end else if (!r_reg.req_n && !primary_grant_n && bus_idle) begin
          // (R2) address with first frame cycle
          r_next.state = PPPS_ADDR;
          r_next.req_n = 1'b1;
          r_next.frame_n = 1'b0;
          r_next.frame_oe = 1'b1;
          r_next.irdy_n = 1'b1;
          r_next.irdy_oe = 1'b1;
          r_next.ad_oe = 1'b1;
          // (R6) command in address phase
          r_next.cbe = r_reg.cmd;
          r_next.cbe_oe = 1'b1;
          r_next.cnt = 3'd0;
          r_next.claimed = 1'b0;
        end else if (r_reg.gap == `PPPS_REQ_GAP) begin
          // (R15) request only after the gap
          r_next.req_n = 1'b0;
        end
      end
      PPPS_ADDR, PPPS_DATA: begin
        r_next.state = PPPS_DATA;
        r_next.claimed = claim;
        r_next.left = left_after;
        if (r_reg.cnt != `PPPS_CLAIM_WAIT) begin
          r_next.cnt = r_reg.cnt + 3'd1;
        end
        if (r_reg.write) begin
          // (R12) irdy released only by a transfer or by a master abort
          // (R4) new word only into an empty slot
          load = (r_reg.irdy_n || xfer) && f_valid && left_after != 8'h00;
          if (load) begin
            r_next.ad = f_word[31:0];
            // (R6) byte enables in data phases
            r_next.cbe = f_word[`PPPS_BE_LSB +: 4];
            r_next.irdy_n = 1'b0;
            // (R11) frame high with the final word
            r_next.frame_n = left_after == 8'h01;
          end else if (xfer) begin
            r_next.irdy_n = 1'b1;
          end
        end else begin
          // bus turned round: the target drives ad on reads
          r_next.ad_oe = 1'b0;
          r_next.cbe = `PPPS_BE_ALL;
          r_next.irdy_n = 1'b0;
          // (R11) frame high in final phase
          r_next.frame_n = left_after == 8'h01;
          if (xfer) begin
            r_next.rd_valid = 1'b1;
            r_next.rd_data = primary_ad_i;
          end
        end
        if (left_after == 8'h00) begin
          r_next.state = PPPS_TURN;
          r_next.done = 1'b1;
        end else if (!claim && r_reg.cnt == `PPPS_CLAIM_WAIT) begin
          // (R14) nobody claimed: master abort
          r_next.state = PPPS_TURN;
          r_next.abort = 1'b1;
        end
        if (r_next.state == PPPS_TURN) begin
          // (R1) drive high one cycle first
          r_next.frame_n = 1'b1;
          r_next.irdy_n = 1'b1;
          r_next.ad_oe = 1'b0;
          r_next.cbe_oe = 1'b0;
        end
      end
      PPPS_TURN: begin
        // (R1) float after the high cycle
        r_next.state = PPPS_IDLE;
        r_next.frame_oe = 1'b0;
        r_next.irdy_oe = 1'b0;
        r_next.busy = 1'b0;
      end
      default: begin
        r_next.state = PPPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.state <= PPPS_IDLE;
      r_reg.req_n <= 1'b1;
      r_reg.frame_n <= 1'b1;
      r_reg.irdy_n <= 1'b1;
      r_reg.ad <= `PPPS_AD_RESET;
      r_reg.cbe <= `PPPS_CBE_RESET;
      r_reg.gap <= `PPPS_REQ_GAP;
      err_reg <= 1'b0;
    end else begin
      r_reg <= r_next;
      err_reg <= par_err;
    end
  end

  assign busy = r_reg.busy;
  assign done = r_reg.done;
  assign master_abort = r_reg.abort;
  assign parity_error = err_reg;
  assign rd_valid = r_reg.rd_valid;
  assign rd_data = r_reg.rd_data;
  assign primary_request_n = r_reg.req_n;
  assign primary_ad_o = r_reg.ad;
  assign primary_cmd_byte_enables_o = r_reg.cbe;
  assign primary_parity_bit_o = par_o;
  assign primary_frame_n_o = r_reg.frame_n;
  assign primary_initiator_ready_n_o = r_reg.irdy_n;
  // (R16) enables cut by reset, not by a clock edge
  assign primary_ad_oe = r_reg.ad_oe && !reset;
  assign primary_cmd_byte_enables_oe = r_reg.cbe_oe && !reset;
  assign primary_parity_bit_oe = par_oe && !reset;
  assign primary_frame_oe = r_reg.frame_oe && !reset;
  assign primary_initiator_ready_oe = r_reg.irdy_oe && !reset;

  // helper state for the checks below
  logic [31:0] addr_seen;
  logic [3:0]  cmd_seen;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_seen <= 32'h0000_0000;
      cmd_seen <= 4'h0;
    end else if (start && start_words != 8'h00 && r_reg.state == PPPS_IDLE) begin
      addr_seen <= start_addr;
      cmd_seen <= start_cmd;
    end
  end

  sequence frame_go_s;
    r_reg.state == PPPS_ADDR;
  endsequence

  sequence no_claim_s;
    primary_target_claim_n_i [*6];
  endsequence

  sequence wr_wait_s;
    r_reg.state == PPPS_DATA && r_reg.write && !r_reg.irdy_n
      && primary_target_ready_n_i && r_reg.claimed;
  endsequence

  release_high_a: assert property ( // (R1)
    @(posedge clk_sys) disable iff (reset)
    $fell(r_reg.frame_oe) |-> $past(r_reg.frame_n) && $past(r_reg.irdy_n)
      && $past(r_reg.state) == PPPS_TURN)
    else $error("control line floated without a high cycle");

  addr_phase_a: assert property ( // (R2)
    @(posedge clk_sys) disable iff (reset)
    frame_go_s |-> !r_reg.frame_n && r_reg.ad_oe && r_reg.ad == addr_seen)
    else $error("address phase without the requested address");

  word_count_a: assert property ( // (R3)
    @(posedge clk_sys) disable iff (reset)
    (r_reg.state == PPPS_DATA && left_after != 8'h00)
      |=> r_reg.left == $past(r_reg.left) - 8'($past(xfer)))
    else $error("word counted without both readies");

  write_hold_a: assert property ( // (R4) (R12)
    @(posedge clk_sys) disable iff (reset)
    wr_wait_s |=> !r_reg.irdy_n && $stable(r_reg.ad) && $stable(r_reg.cbe))
    else $error("write word or ready changed before transfer");

  park_drive_a: assert property ( // (R5)
    @(posedge clk_sys) disable iff (reset)
    (r_reg.state == PPPS_IDLE && !primary_grant_n && bus_idle)
      |=> r_reg.ad_oe && r_reg.cbe_oe ##1 par_oe)
    else $error("granted idle bus not parked");

  cmd_phase_a: assert property ( // (R6)
    @(posedge clk_sys) disable iff (reset)
    frame_go_s |-> r_reg.cbe == cmd_seen && r_reg.cbe_oe)
    else $error("command missing in address phase");

  par_value_a: assert property ( // (R7) (R9)
    @(posedge clk_sys) disable iff (reset)
    par_oe |-> par_o == ppps_even_par($past(r_reg.ad), $past(r_reg.cbe)))
    else $error("driven parity not even or not one clock late");

  par_release_a: assert property ( // (R10)
    @(posedge clk_sys) disable iff (reset)
    $fell(r_reg.ad_oe) |=> $fell(par_oe))
    else $error("parity not released one cycle after ad");

  frame_last_a: assert property ( // (R11)
    @(posedge clk_sys) disable iff (reset)
    (r_reg.state == PPPS_DATA && !r_reg.irdy_n && r_reg.frame_n)
      |-> r_reg.left == 8'h01)
    else $error("frame released before the final phase");

  abort_window_a: assert property ( // (R14)
    @(posedge clk_sys) disable iff (reset)
    frame_go_s ##0 no_claim_s |=> r_reg.state == PPPS_TURN && r_reg.abort)
    else $error("missing master abort after unclaimed frame");

  req_gap_a: assert property ( // (R15)
    @(posedge clk_sys) disable iff (reset)
    $rose(r_reg.req_n) |-> r_reg.req_n [*2])
    else $error("request reasserted too soon");

  reset_float_a: assert property ( // (R16)
    @(posedge clk_sys)
    reset |-> !primary_ad_oe && !primary_cmd_byte_enables_oe
      && !primary_parity_bit_oe && !primary_frame_oe
      && !primary_initiator_ready_oe)
    else $error("bus output driven during reset");
endmodule
`default_nettype wire

// [dv/ppps_tgt_model.sv]
/*
  Target on the far side of the primary port: claims after a set
  latency, inserts wait states, serves read words and their parity,
  and reports each write word it takes.
  Assumes resolved bus levels from the bench and one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ppps_tgt_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // resolved bus
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe,
  // target drive
  output logic             trdy_n,
  output logic             claim_n,
  output logic [31:0]      ad_drv,
  output logic             ad_en,
  output logic             par_drv,
  output logic             par_en,
  // scenario control
  input  wire logic [3:0]  lat,
  input  wire logic [1:0]  wst,
  input  wire logic        bad_par,
  // write words taken
  output logic             seen,
  output logic [31:0]      seen_ad,
  output logic [3:0]       seen_be
);
  logic        act, wr, x, cl;
  logic [7:0]  k, idx;
  logic [1:0]  wt;
  logic [31:0] base;
  always @(posedge clk_sys) begin
    if (reset) begin
      act = 1'h0;
      trdy_n  <= 1'h1;
      claim_n <= 1'h1;
      ad_en   <= 1'h0;
      par_en  <= 1'h0;
      seen    <= 1'h0;
    end else begin
      x = act && !irdy_n && !trdy_n;
      seen    <= x && wr;
      seen_ad <= ad;
      seen_be <= cbe;
      par_en  <= x && !wr;
      par_drv <= ^{ad, cbe} ^ bad_par;
      // high frame on a moved word ends it
      if (act && (x ? frame_n : frame_n && irdy_n)) begin
        act = 1'h0;
      end else if (act) begin
        k = k + 8'h01;
        if (x) begin
          idx = idx + 8'h01;
          wt = wst;
        end else if (!claim_n && wt != 2'h0) begin
          wt = wt - 2'h1;
        end
      // address and command at frame start
      end else if (!frame_n) begin
        act = 1'h1;
        k = 8'h00;
        wt = wst;
        wr = cbe[0];
        base = ad;
        idx = 8'h00;
      end
      cl = act && (k + 8'h01 >= {4'h0, lat});
      // held until moved, then driven high
      claim_n <= !cl;
      trdy_n  <= !(cl && wt == 2'h0);
      ad_en   <= act && !wr && cl && wt == 2'h0;
      ad_drv  <= {base[31:8], idx};
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
/*
  Bench of the primary port: burst table, then ignored start, parking,
  reset float, read parity fault and a fill of the word buffer.
  Assumes the target model and pull-ups on frame and ready lines.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    logic wr; logic [3:0] cmd; logic [31:0] a; logic [7:0] n;
    logic [3:0] lat; logic [1:0] wst; logic ab;
  } ppps_row_t;
  ppps_row_t rows [5] = '{
    '{1'h1, 4'h7, 32'h1000_0000, 8'h01, 4'h1, 2'h0, 1'h0},
    '{1'h1, 4'h7, 32'h2000_0100, 8'h04, 4'h5, 2'h2, 1'h0},
    '{1'h0, 4'h6, 32'h3000_0200, 8'h01, 4'h1, 2'h0, 1'h0},
    '{1'h0, 4'h6, 32'h4000_0300, 8'h05, 4'h3, 2'h1, 1'h0},
    '{1'h0, 4'h6, 32'h5000_0400, 8'h03, 4'hF, 2'h0, 1'h1}};
  logic clk_sys = 0, reset = 1, start = 0, start_write = 0, wr_valid = 0;
  logic [3:0]  start_cmd = 0, lat = 1, cbe_o, cbe_l = 0;
  logic [31:0] start_addr = 0, ad_o, ad_l = 0, t_ad, rd_data, seen_ad;
  logic [7:0]  start_words = 0;
  logic [35:0] wr_word = 0;
  logic [1:0]  wst = 0;
  logic grant_n = 0, bad_par = 0, busy, done, master_abort, parity_error;
  logic wr_ready, rd_valid, req_n, ad_oe, cbe_oe, par_o, par_oe, par_l = 0;
  logic fn_o, foe, in_o, ioe, trdy_n, claim_n, t_aden, t_par, t_paren, seen;
  logic [3:0]  seen_be;
  logic [31:0] ad_w, exp_a;
  logic [3:0]  cbe_w, exp_c;
  logic        par_w, fn_w, in_w;
  int mismatches = 0, cmp_count = 0, nwr, nrd, nab, ndone, nperr, cyc = 0;
  int addr_cyc = 0, hi = 8, got;
  logic [31:0] p_ad;
  logic [3:0]  primary_cmd_byte_enables;
  logic p_adoe, p_fn = 1, p_foe, p_fno, p_ioe, p_ino, p_trdy, p_rst = 1;
  logic rel = 0;
  // undriven ad, cbe and par show the inverse of their last level; frame and irdy read high
  assign ad_w  = ad_oe ? ad_o : t_aden ? t_ad : ~ad_l;
  assign cbe_w = cbe_oe ? cbe_o : ~cbe_l;
  assign par_w = par_oe ? par_o : t_paren ? t_par : ~par_l;
  assign fn_w  = foe ? fn_o : 1'h1;
  assign in_w  = ioe ? in_o : 1'h1;
  always #5 clk_sys = ~clk_sys;
  ppps_port i_dut (.clk_sys(clk_sys), .reset(reset), .start(start),
    .start_write(start_write), .start_cmd(start_cmd),
    .start_addr(start_addr), .start_words(start_words), .busy(busy),
    .done(done), .master_abort(master_abort), .parity_error(parity_error),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
    .rd_valid(rd_valid), .rd_data(rd_data), .primary_request_n(req_n),
    .primary_grant_n(grant_n), .primary_ad_i(ad_w), .primary_ad_o(ad_o),
    .primary_ad_oe(ad_oe), .primary_cmd_byte_enables_i(cbe_w),
    .primary_cmd_byte_enables_o(cbe_o),
    .primary_cmd_byte_enables_oe(cbe_oe), .primary_parity_bit_i(par_w),
    .primary_parity_bit_o(par_o), .primary_parity_bit_oe(par_oe),
    .primary_frame_n_i(fn_w), .primary_frame_n_o(fn_o),
    .primary_frame_oe(foe), .primary_initiator_ready_n_i(in_w),
    .primary_initiator_ready_n_o(in_o), .primary_initiator_ready_oe(ioe),
    .primary_target_ready_n_i(trdy_n), .primary_target_claim_n_i(claim_n));
  ppps_tgt_model i_tgt (.clk_sys(clk_sys), .reset(reset), .frame_n(fn_w),
    .irdy_n(in_w), .ad(ad_w), .cbe(cbe_w), .trdy_n(trdy_n),
    .claim_n(claim_n), .ad_drv(t_ad), .ad_en(t_aden), .par_drv(t_par),
    .par_en(t_paren), .lat(lat), .wst(wst), .bad_par(bad_par),
    .seen(seen), .seen_ad(seen_ad), .seen_be(seen_be));
  task automatic check(input string what, input logic [35:0] s,
                       input logic [35:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    ad_l <= ad_w;
    cbe_l <= cbe_w;
    par_l <= par_w;
    if (!reset && !p_rst) begin
      if (par_oe === 1'h1 && p_adoe === 1'h1)
        check("par", par_o, ^{p_ad, primary_cmd_byte_enables});
      if (rel) check("par_rel", par_oe, 1'h0);
      rel = p_adoe === 1'h1 && ad_oe === 1'h0;
      if (rel) check("par_late", par_oe, 1'h1);
      if (p_foe === 1'h1 && foe === 1'h0) check("frame_hi", p_fno, 1'h1);
      if (p_ioe === 1'h1 && ioe === 1'h0) check("irdy_hi", p_ino, 1'h1);
      if (p_ioe === 1'h1 && p_ino === 1'h0 && p_trdy === 1'h1
          && master_abort !== 1'h1) begin
        check("irdy_hold", in_o, 1'h0);
        if (p_adoe === 1'h1) check("ad_hold", ad_o, p_ad);
      end
      if (foe === 1'h1 && fn_o === 1'h0 && p_fn === 1'h1) begin
        addr_cyc = cyc;
        check("addr", ad_o, exp_a);
        check("cmd", cbe_o, exp_c);
      end
    end
    if (reset) hi = 8;
    else if (req_n === 1'h1) hi++;
    else begin
      if (hi != 0) check("req_gap", hi >= 2, 1'h1);
      hi = 0;
    end
    if (seen === 1'h1) begin
      check("wr_ad", seen_ad, {exp_a[31:8], nwr[7:0]});
      check("wr_be", seen_be, nwr[3:0]);
      nwr++;
    end
    if (rd_valid === 1'h1) begin
      check("rd", rd_data, {exp_a[31:8], nrd[7:0]});
      nrd++;
    end
    if (master_abort === 1'h1) begin
      check("ab_lag", cyc - addr_cyc inside {6, 7}, 1'h1);
      nab++;
    end
    if (done === 1'h1) ndone++;
    if (parity_error === 1'h1) nperr++;
    {p_ad, primary_cmd_byte_enables, p_adoe, p_fn, p_foe, p_fno} <=
      {ad_o, cbe_o, ad_oe, fn_w, foe, fn_o};
    {p_ioe, p_ino, p_trdy, p_rst} <= {ioe, in_o, trdy_n, reset};
  end
  task automatic fill(input int n, input logic [31:0] a, output int g);
    g = 0;
    for (int t = 0; t < n + 20 && g < n; t++) begin
      @(negedge clk_sys);
      wr_valid = 1'h1;
      wr_word = {g[3:0], a[31:8], g[7:0]};
      @(posedge clk_sys);
      if (wr_ready === 1'h1) g++;
    end
    @(negedge clk_sys);
    wr_valid = 1'h0;
  endtask
  task automatic run(input ppps_row_t r, input bit pre, input int ep);
    int t;
    {exp_a, exp_c, lat, wst} = {r.a, r.cmd, r.lat, r.wst};
    {nwr, nrd, nab, ndone, nperr} = '0;
    if (pre) begin
      fill(r.n, r.a, got);
      check("filled", got, r.n);
    end
    @(negedge clk_sys);
    {start, start_write, start_cmd, start_addr, start_words} =
      {1'h1, r.wr, r.cmd, r.a, r.n};
    @(negedge clk_sys);
    start = 1'h0;
    for (t = 0; t < 500 && busy !== 1'h0; t++) @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
    if (t == 500) begin
      mismatches++;
      give_verdict();
    end
    check("done", ndone, !r.ab);
    check("abort", nab, r.ab);
    check("wr_cnt", nwr, r.wr && !r.ab ? r.n : 8'h00);
    check("rd_cnt", nrd, !r.wr && !r.ab ? r.n : 8'h00);
    check("perr", nperr, ep);
    $display("burst at %h done", r.a);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    reset = 1'h0;
    foreach (rows[i]) run(rows[i], rows[i].wr, 0);
    // ignored start of zero words
    @(negedge clk_sys);
    {start, start_words} = {1'h1, 8'h00};
    @(negedge clk_sys);
    start = 1'h0;
    repeat (3) @(negedge clk_sys);
    check("busy0", busy, 1'h0);
    check("park", {ad_oe, cbe_oe, par_oe}, 3'h7);
    // grant taken away: parking must stop, parity a cycle later
    grant_n = 1'h1;
    repeat (3) @(negedge clk_sys);
    check("unpark", {ad_oe, cbe_oe, par_oe}, 3'h0);
    grant_n = 1'h0;
    reset = 1'h1;
    #1;
    check("float", {ad_oe, cbe_oe, par_oe, foe, ioe}, 5'h00);
    repeat (2) @(negedge clk_sys);
    reset = 1'h0;
    $display("park and reset test done");
    bad_par = 1'h1;
    run('{1'h0, 4'h6, 32'h6000_0500, 8'h01, 4'h2, 2'h0, 1'h0}, 1'h0, 1);
    bad_par = 1'h0;
    fill(40, 32'h7000_0600, got);
    check("fifo_full", got, 32);
    run('{1'h1, 4'h7, 32'h7000_0600, 8'h20, 4'h2, 2'h1, 1'h0}, 1'h0, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
